//--- core/uhie_pkg.sv
// package: offsets, field layouts and reset values of the host interrupt enable block
package uhie_pkg;
	// ==========================================================================
	// register offsets (byte addresses)
	localparam logic [11:0] OFF_FLAG_FORCE = 12'h40c;
	localparam logic [11:0] OFF_EN         = 12'h410;
	localparam logic [11:0] OFF_EN_CLR     = 12'h414;
	localparam logic [11:0] OFF_EN_SET     = 12'h418;
	localparam logic [11:0] OFF_IRQ_STAT   = 12'h480;
	localparam logic [11:0] OFF_IRQ_MASK   = 12'h484;

	// ==========================================================================
	// field layout shared by flags, enables and their set/clear/force ports
	localparam int EVT_LSB  = 0;
	localparam int EVT_W    = 7;
	localparam int PIPE_LSB = 8;
	localparam int PIPE_W   = 7;
	localparam int DMA_LSB  = 25;
	localparam int DMA_W    = 6;
	localparam logic [31:0] EN_VALID    = 32'h7e00_7f7f;
	localparam logic [31:0] FORCE_VALID = 32'h7e00_007f;
	localparam logic [31:0] EN_RST      = 32'h0000_0000;

	// ==========================================================================
	// local interrupt status bits
	localparam int ST_REQ_RISE = 0;
	localparam int ST_BUS_ERR  = 1;
	localparam int ST_COLLIDE  = 2;
	localparam int ST_W        = 3;
	localparam logic [ST_W-1:0] ST_RST = 3'h0;

	// ==========================================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- core/uhie_top.sv
// host interrupt enable registers, flag-force ports and interrupt request merge
// ============================================================================
// Overview of operation
// - force bits set the matching host event flags
// - zero writes do nothing; ports read zero
// - force bits set DMA channel 1..6 flags
// - enable register at 0x410, resets zero, read-only
// - event enables sit in bits 6..0
// - pipe enables sit in bits 14..8
// - DMA channel enables sit in bits 30..25
// - clear port at 0x414 clears enable bits
// - set port at 0x418 sets enable bits
// - force port at 0x40c, flag layout
// - only enabled flags raise the USB request
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none

module uhie_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	// axi4-lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// flag sources
	input  wire logic [6:0]  host_evt_flag,
	input  wire logic [6:0]  pipe_flag,
	input  wire logic [5:0]  dma_chan_flag,
	output logic [6:0]       host_evt_flag_force,
	output logic [5:0]       dma_chan_flag_force,
	// interrupt outputs
	output logic             usb_irq_req,
	output logic             irq
);

	// ========================================================================
	// helpers
	// byte enables widened to a bit mask
	// a partial write sets or clears no bits in lanes it did not write, except the mask bits, which it writes as zero
	function automatic logic [31:0] strb_mask(input logic [3:0] strb);
		strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// address decode, shared by the read and write paths
	function automatic logic is_mapped(input logic [11:0] addr);
		is_mapped = (addr == uhie_pkg::OFF_FLAG_FORCE) || (addr == uhie_pkg::OFF_EN)
			|| (addr == uhie_pkg::OFF_EN_CLR) || (addr == uhie_pkg::OFF_EN_SET)
			|| (addr == uhie_pkg::OFF_IRQ_STAT) || (addr == uhie_pkg::OFF_IRQ_MASK);
	endfunction

	// ========================================================================
	// state
	// bus side
	logic [11:0]            awaddr_ff;
	logic                   aw_held_ff;
	logic [31:0]            wdata_ff;
	logic                   w_held_ff;
	logic                   bvalid_ff;
	logic [1:0]             bresp_ff;
	logic [31:0]            rdata_ff;
	logic [1:0]             rresp_ff;
	logic                   rvalid_ff;
	// register contents
	logic [31:0]            en_ff;
	logic [6:0]             evt_force_ff;
	logic [5:0]             dma_force_ff;
	logic                   usb_req_ff;
	// local interrupt
	logic [uhie_pkg::ST_W-1:0] stat_ff;
	logic [uhie_pkg::ST_W-1:0] mask_ff;
	logic                   irq_ff;

	// ========================================================================
	// write channel decode
	wire        aw_take  = s_axi_awvalid & s_axi_awready;
	wire        w_take   = s_axi_wvalid & s_axi_wready;
	// the write acts in the first clock in which both halves are held; holding both first
	// lets address and data arrive in either order with no extra muxing
	wire        wr_go    = aw_held_ff & w_held_ff & ~bvalid_ff;
	wire        wr_map   = is_mapped(awaddr_ff);
	// decoded strobes, each high for the single clock in which the write acts
	wire        wr_force = wr_go & (awaddr_ff == uhie_pkg::OFF_FLAG_FORCE);
	wire        wr_clr   = wr_go & (awaddr_ff == uhie_pkg::OFF_EN_CLR);
	wire        wr_set   = wr_go & (awaddr_ff == uhie_pkg::OFF_EN_SET);
	wire        wr_stat  = wr_go & (awaddr_ff == uhie_pkg::OFF_IRQ_STAT);
	wire        wr_mask  = wr_go & (awaddr_ff == uhie_pkg::OFF_IRQ_MASK);
	wire        wr_bad   = wr_go & ~wr_map;

	// each half is refused while it is held or while the answer waits, so a
	// second write can never overwrite the first before it has acted
	assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
	assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// ========================================================================
	// enable set/clear: only ones act, zeros leave the enables alone
	wire [31:0] set_bits = wr_set ? (wdata_ff & uhie_pkg::EN_VALID) : 32'h0000_0000;
	wire [31:0] clr_bits = wr_clr ? (wdata_ff & uhie_pkg::EN_VALID) : 32'h0000_0000;
	// the two ports sit at separate addresses, so one write names a bit in
	// both only if the ports are ever merged; the priority is fixed anyway
	// clear applied after set, so a bit named in both ends up cleared
	wire [31:0] nxt_en   = (en_ff | set_bits) & ~clr_bits & uhie_pkg::EN_VALID;

	// force port: mirrors the flag layout, one-cycle pulse per written one
	// pipe flags follow their pipes and cannot be forced: those bits drop out
	wire [31:0] force_bits = wr_force ? (wdata_ff & uhie_pkg::FORCE_VALID) : 32'h0000_0000;
	wire [6:0]  nxt_evt_force = force_bits[uhie_pkg::EVT_LSB +: uhie_pkg::EVT_W];
	wire [5:0]  nxt_dma_force = force_bits[uhie_pkg::DMA_LSB +: uhie_pkg::DMA_W];

	// ========================================================================
	// request merge: each flag group is gated by its own slice of the enables
	// enable views, one per field, so the gating below reads like the layout
	wire [6:0]  en_evt   = en_ff[uhie_pkg::EVT_LSB +: uhie_pkg::EVT_W];
	wire [6:0]  en_pipe  = en_ff[uhie_pkg::PIPE_LSB +: uhie_pkg::PIPE_W];
	wire [5:0]  en_dma   = en_ff[uhie_pkg::DMA_LSB +: uhie_pkg::DMA_W];
	// per-group requests; a flag whose enable is clear drops out here
	wire        req_evt  = |(host_evt_flag & en_evt);
	wire        req_pipe = |(pipe_flag & en_pipe);
	wire        req_dma  = |(dma_chan_flag & en_dma);
	// the request is registered, so it lags the flags by one clock; a flag
	// that stands for a single cycle still reaches it
	wire        nxt_usb_req = req_evt | req_pipe | req_dma;

	// ========================================================================
	// local status: sticky events, set wins over a same-cycle clear
	// bit 2 stays low while set and clear are separate ports; it is kept so
	// that the status layout need not move if the ports are ever merged
	wire [uhie_pkg::ST_W-1:0] st_evt = {(|(set_bits & clr_bits)), wr_bad, nxt_usb_req & ~usb_req_ff};
	wire [uhie_pkg::ST_W-1:0] st_clr = wr_stat ? wdata_ff[uhie_pkg::ST_W-1:0] : 3'h0;
	wire [uhie_pkg::ST_W-1:0] nxt_stat = (stat_ff & ~st_clr) | st_evt;
	wire [uhie_pkg::ST_W-1:0] nxt_mask = wr_mask ? wdata_ff[uhie_pkg::ST_W-1:0] : mask_ff;
	wire                      nxt_irq  = |(nxt_stat & nxt_mask);

	// ========================================================================
	// read decode: write-only ports and reserved bits read as zero
	wire        ar_take = s_axi_arvalid & s_axi_arready;
	// low address bits are dropped as on the write side, so both paths decode alike
	wire [11:0] rd_addr = {s_axi_araddr[11:2], 2'h0};
	wire        rd_map  = is_mapped(rd_addr);
	wire        rd_en   = (rd_addr == uhie_pkg::OFF_EN);
	wire        rd_stat = (rd_addr == uhie_pkg::OFF_IRQ_STAT);
	wire        rd_mask = (rd_addr == uhie_pkg::OFF_IRQ_MASK);
	wire [31:0] rd_mux  =
		rd_en   ? en_ff :
		rd_stat ? {29'h0, stat_ff} :
		rd_mask ? {29'h0, mask_ff} :
		32'h0000_0000;

	assign s_axi_arready = ~rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// ========================================================================
	// write address holding; the low two address bits are dropped since
	// every register is one aligned word
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			awaddr_ff  <= 12'h000;
			aw_held_ff <= 1'b0;
		end else if (aw_take) begin
			awaddr_ff  <= {s_axi_awaddr[11:2], 2'h0};
			aw_held_ff <= 1'b1;
		end else if (wr_go) begin
			aw_held_ff <= 1'b0;
		end
	end

	// write data holding; lanes with a low strobe act as zero, which the
	// set, clear and force ports treat as leave alone
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wdata_ff  <= 32'h0000_0000;
			w_held_ff <= 1'b0;
		end else if (w_take) begin
			wdata_ff  <= s_axi_wdata & strb_mask(s_axi_wstrb); // unwritten lanes act as zero
			w_held_ff <= 1'b1;
		end else if (wr_go) begin
			w_held_ff <= 1'b0;
		end
	end

	// write response; an unmapped address answers with an error and
	// sets only the bus error status bit
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= uhie_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_map ? uhie_pkg::RESP_OKAY : uhie_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// read answer, one cycle after the address is taken
	// data is latched at the take, so it stands unchanged until rready
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h0000_0000;
			rresp_ff  <= uhie_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= rd_map ? uhie_pkg::RESP_OKAY : uhie_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	// ========================================================================
	// enable register; only the set and clear ports move it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_ff <= uhie_pkg::EN_RST;
		end else begin
			en_ff <= nxt_en;
		end
	end

	// force pulses last one clock; the flag sources latch them as sets,
	// so a longer pulse would only hide a second force write
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_force_ff <= 7'h00;
			dma_force_ff <= 6'h00;
		end else begin
			evt_force_ff <= nxt_evt_force;
			dma_force_ff <= nxt_dma_force;
		end
	end

	// registered request: one clock of latency buys a glitch-free output
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			usb_req_ff <= 1'b0;
		end else begin
			usb_req_ff <= nxt_usb_req;
		end
	end

	assign host_evt_flag_force = evt_force_ff;
	assign dma_chan_flag_force = dma_force_ff;
	assign usb_irq_req         = usb_req_ff;

	// ========================================================================
	// local status: a set in the same clock as a clear wins, so an event is
	// never lost to a clear that software aimed at an older one
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_ff <= uhie_pkg::ST_RST;
		end else begin
			stat_ff <= nxt_stat;
		end
	end

	// mask: plain read/write bits
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mask_ff <= uhie_pkg::ST_RST;
		end else begin
			mask_ff <= nxt_mask;
		end
	end

	// interrupt output, registered from the next status and mask so it
	// rises in the same clock as the status bit that causes it
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	assign irq = irq_ff;

endmodule

`default_nettype wire

//--- sim/uhie_chk.sv
// checker: bus timing, force pulses and request merge of the enable block
`timescale 1ns/1ns
`default_nettype none
module uhie_chk (
	input wire logic       core_clk,
	input wire logic       rst_b,
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic [1:0] s_axi_bresp,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready,
	input wire logic [6:0] host_evt_flag,
	input wire logic [6:0] pipe_flag,
	input wire logic [5:0] dma_chan_flag,
	input wire logic [6:0] host_evt_flag_force,
	input wire logic [5:0] dma_chan_flag_force,
	input wire logic       usb_irq_req
);
	// ==========================================================
	// one domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
	a_read_hold: assert property (
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while answer waits");
	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer timing");
	a_resp_hold: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready
		&& (s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2)) else $error("write taken while answer waits");
	a_evt_pulse: assert property (
		|host_evt_flag_force |=> host_evt_flag_force == 7'h0) else $error("event force too long");
	a_dma_pulse: assert property (
		|dma_chan_flag_force |=> dma_chan_flag_force == 6'h0) else $error("dma force too long");
	a_force_cause: assert property (
		(|host_evt_flag_force || |dma_chan_flag_force) |-> $rose(s_axi_bvalid)
		&& s_axi_bresp == 2'h0) else $error("force without write");
	a_req_cause: assert property (
		usb_irq_req |-> $past(|{host_evt_flag, pipe_flag, dma_chan_flag}))
		else $error("request without flag");
endmodule
bind uhie_top uhie_chk chk_u (.*);
`default_nettype wire

//--- sim/testbench.sv
// testbench: enable ports, force ports, request merge and local interrupt
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, en_m = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [6:0]  host_evt_flag = 7'h0, pipe_flag = 7'h0, host_evt_flag_force, fev;
	logic [5:0]  dma_chan_flag = 6'h0, dma_chan_flag_force, fdm;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, usb_irq_req, irq;
	int          num_errors = 0, checked = 0;
	// ==========================================================
	// clock and design
	always #2 core_clk = ~core_clk;
	uhie_top dut_u (.*);
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// ==========================================================
	// bus cycles; each channel is released at the edge that takes it, and
	// bready/rready stand from the start until the answer is sampled
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic aw_open;
		logic w_open;
		@(posedge core_clk);
		aw_open = 1'b1;
		w_open = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (aw_open && s_axi_awready === 1'b1) begin
				aw_open = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w_open && s_axi_wready === 1'b1) begin
				w_open = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1);
		fev = host_evt_flag_force; // force pulse stands with the answer
		fdm = dma_chan_flag_force;
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		logic ar_open;
		@(posedge core_clk);
		ar_open = 1'b1;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (ar_open && s_axi_arready === 1'b1) begin
				ar_open = 1'b0;
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_enable();
		rd(uhie_pkg::OFF_EN);
		chk("en reset", 32'h0, rv);
		wr(uhie_pkg::OFF_EN_SET, 32'hffff_ffff);
		rd(uhie_pkg::OFF_EN);
		chk("en set", 32'h7e00_7f7f, rv);
		wr(uhie_pkg::OFF_EN_CLR, 32'h4000_0101);
		wr(uhie_pkg::OFF_EN_CLR, 32'h0);
		wr(uhie_pkg::OFF_EN, 32'h0);
		chk("ro resp", 32'(uhie_pkg::RESP_OKAY), 32'(rr));
		rd(uhie_pkg::OFF_EN);
		en_m = 32'h3e00_7e7e;
		chk("en clear", en_m, rv);
		rd(uhie_pkg::OFF_FLAG_FORCE);
		chk("force read", 32'h0, rv);
		rd(uhie_pkg::OFF_EN_CLR);
		chk("clear read", 32'h0, rv);
		rd(uhie_pkg::OFF_EN_SET);
		chk("set read", 32'h0, rv);
		chk("wo resp", 32'(uhie_pkg::RESP_OKAY), 32'(rr));
	endtask
	task automatic t_force();
		logic [31:0] b;
		for (int i = 0; i < 13; i++) begin
			b = (i < 7) ? (32'h1 << i) : (32'h1 << (i + 18));
			wr(uhie_pkg::OFF_FLAG_FORCE, b);
			chk("evt force", 32'(b[6:0]), 32'(fev));
			chk("dma force", 32'(b[30:25]), 32'(fdm));
		end
		wr(uhie_pkg::OFF_FLAG_FORCE, 32'h0000_ff00);
		chk("zero force", 32'h0, {19'h0, fev, fdm});
	endtask
	task automatic t_req();
		logic [31:0] v;
		for (int i = 0; i < 31; i++) begin
			v = 32'h1 << i;
			host_evt_flag <= v[6:0];
			pipe_flag <= v[14:8];
			dma_chan_flag <= v[30:25];
			repeat (3) @(posedge core_clk);
			chk("irq req", 32'(|(v & en_m)), 32'(usb_irq_req));
		end
		host_evt_flag <= 7'h0;
		pipe_flag <= 7'h0;
		dma_chan_flag <= 6'h0;
	endtask
	task automatic t_irq();
		wr(12'h7f0, 32'h1);
		chk("unmapped wr", 32'(uhie_pkg::RESP_SLVERR), 32'(rr));
		chk("irq masked", 32'h0, 32'(irq));
		wr(uhie_pkg::OFF_IRQ_MASK, 32'h2);
		rd(uhie_pkg::OFF_IRQ_STAT);
		chk("status", 32'h3, rv);
		chk("irq on", 32'h1, 32'(irq));
		wr(uhie_pkg::OFF_IRQ_STAT, 32'h3);
		rd(uhie_pkg::OFF_IRQ_STAT);
		chk("status clr", 32'h0, rv);
		chk("irq off", 32'h0, 32'(irq));
	endtask
	// ==========================================================
	// verdict, main sequence and watchdog
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b1;
		t_enable();
		$display("enable test done");
		t_force();
		$display("force test done");
		t_req();
		$display("request test done");
		t_irq();
		$display("interrupt test done");
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		num_errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
